/* File: rtl/port_expander.sv */
// Slave addressing, open-drain ports and change alert of an eight-bit I2C port expander
`default_nettype none
module port_expander
#(
	parameter bit HIGH_RANGE = 1'b0
)
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic [2:0] ADDR_STRAP,
	input wire logic [7:0] EXPANDER_PORT_PINS_IN,
	output logic [7:0] EXPANDER_PORT_PINS_OUT,
	output logic [7:0] EXPANDER_PORT_PINS_OE,
	output logic INT_OUT,
	output logic INT_OE
);
	localparam int ALERT_REL_CYC = expander_pkg::ALERT_RELEASE_CYC;

	logic rst_s1_r;
	logic rst_n;
	expander_pkg::pin_sample_type meta_r;
	expander_pkg::pin_sample_type samp_r;
	expander_pkg::pin_sample_type prev_r;
	expander_pkg::link_state_type state_r, state_nxt;
	logic [3:0] bit_cnt_r, bit_cnt_nxt;
	logic rw_r, rw_nxt;
	logic drive_r, drive_nxt;
	logic [7:0] rd_sh_r, rd_sh_nxt;
	logic [7:0] wr_byte_r, wr_byte_nxt;
	logic [7:0] port_low_r, port_low_nxt;
	logic wr_clr_r, wr_clr_nxt;
	logic [7:0] ref_r;
	logic int_r, int_nxt;
	logic [7:0] rx_byte;
	logic sda_oe_link;

	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	// Every pin is asynchronous to CLK; the first stage feeds only the second
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= '1;
			samp_r <= '1;
			prev_r <= '1;
		end
		else
		begin
			meta_r <= {SCL, SDA_IN, ADDR_STRAP, EXPANDER_PORT_PINS_IN};
			samp_r <= meta_r;
			prev_r <= samp_r;
		end
	end

	link_shifter u_link
	(
		.scl(SCL),
		.rst_n(rst_n),
		.sda_in(SDA_IN),
		.drive_low(drive_r),
		.rx_byte(rx_byte),
		.sda_oe(sda_oe_link)
	);

	expander_pkg::bus_event_type ev;
	assign ev.start = prev_r.scl & samp_r.scl & prev_r.sda & ~samp_r.sda;
	assign ev.stop = prev_r.scl & samp_r.scl & ~prev_r.sda & samp_r.sda;
	assign ev.rise = samp_r.scl & ~prev_r.scl;
	assign ev.fall = ~samp_r.scl & prev_r.scl;

	wire logic [3:0] prefix = HIGH_RANGE ? expander_pkg::PREFIX_HIGH_RANGE
		: expander_pkg::PREFIX_LOW_RANGE;
	// Straps are only read once synchronised; they are expected not to move
	wire logic [6:0] own_addr = {prefix, samp_r.strap};
	wire logic active = state_r != expander_pkg::ST_IDLE;
	wire logic byte_done = ev.rise & active & (bit_cnt_r == expander_pkg::LAST_DATA_BIT);
	wire logic ack_rise = ev.rise & active & (bit_cnt_r == expander_pkg::ACK_SLOT);
	wire logic in_addr = state_r == expander_pkg::ST_ADDR;
	wire logic addr_hit = byte_done & in_addr & (rx_byte[7:1] == own_addr);
	wire logic addr_miss = byte_done & in_addr & (rx_byte[7:1] != own_addr);
	wire logic rd_clear = ack_rise & in_addr & (rw_r == expander_pkg::RW_READ);
	wire logic wr_clear = ev.fall & wr_clr_r;
	wire logic alert_clear = rd_clear | wr_clear;
	wire logic [7:0] port_bits = ~port_low_r;
	wire logic [7:0] pin_diff = (samp_r.pins ^ ref_r) & port_bits;
	wire logic [7:0] pin_edge = (samp_r.pins ^ prev_r.pins) & port_bits;

	always_comb
	begin
		state_nxt = state_r;
		bit_cnt_nxt = bit_cnt_r;
		rw_nxt = rw_r;
		drive_nxt = drive_r;
		rd_sh_nxt = rd_sh_r;
		wr_byte_nxt = wr_byte_r;
		port_low_nxt = port_low_r;
		wr_clr_nxt = wr_clr_r & ~ev.fall;
		if (ev.rise && active)
			bit_cnt_nxt = ack_rise ? expander_pkg::BIT_FIRST : bit_cnt_r + 4'h1;
		if (ev.start || ev.stop)
		begin
			state_nxt = ev.start ? expander_pkg::ST_ADDR : expander_pkg::ST_IDLE;
			bit_cnt_nxt = expander_pkg::BIT_FIRST;
			drive_nxt = 1'b0;
		end
		else
		begin
			unique case (state_r)
				expander_pkg::ST_IDLE:
					drive_nxt = 1'b0;
				expander_pkg::ST_ADDR:
				begin
					if (addr_hit)
					begin
						rw_nxt = rx_byte[0];
						drive_nxt = 1'b1;
					end
					else if (addr_miss)
						state_nxt = expander_pkg::ST_IDLE;
					else if (ack_rise && rw_r == expander_pkg::RW_READ)
					begin
						// Snapshot of the pins during the address acknowledge
						state_nxt = expander_pkg::ST_READ;
						rd_sh_nxt = samp_r.pins;
						drive_nxt = ~samp_r.pins[7];
					end
					else if (ack_rise)
					begin
						state_nxt = expander_pkg::ST_WRITE;
						drive_nxt = 1'b0;
					end
				end
				expander_pkg::ST_WRITE:
				begin
					if (byte_done)
					begin
						wr_byte_nxt = rx_byte;
						drive_nxt = 1'b1;
					end
					else if (ack_rise)
					begin
						port_low_nxt = ~wr_byte_r;
						wr_clr_nxt = 1'b1;
						drive_nxt = 1'b0;
					end
				end
				expander_pkg::ST_READ:
				begin
					if (byte_done)
						drive_nxt = 1'b0;
					else if (ack_rise && !rx_byte[0])
					begin
						rd_sh_nxt = samp_r.pins;
						drive_nxt = ~samp_r.pins[7];
					end
					else if (ack_rise)
						state_nxt = expander_pkg::ST_IDLE;
					else if (ev.rise)
					begin
						rd_sh_nxt = {rd_sh_r[6:0], 1'b0};
						drive_nxt = ~rd_sh_r[6];
					end
				end
			endcase
		end
	end

	// A pin that moves in the clearing cycle keeps the alert up: set beats clear
	assign int_nxt = alert_clear ? |pin_edge : |pin_diff;

	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= expander_pkg::ST_IDLE;
			bit_cnt_r <= expander_pkg::BIT_FIRST;
			rw_r <= 1'b0;
			drive_r <= 1'b0;
			rd_sh_r <= '0;
			wr_byte_r <= '0;
			port_low_r <= ~expander_pkg::PORT_RESET;
			wr_clr_r <= 1'b0;
			ref_r <= expander_pkg::PORT_RESET;
			int_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			rw_r <= rw_nxt;
			drive_r <= drive_nxt;
			rd_sh_r <= rd_sh_nxt;
			wr_byte_r <= wr_byte_nxt;
			port_low_r <= port_low_nxt;
			wr_clr_r <= wr_clr_nxt;
			ref_r <= alert_clear ? prev_r.pins : ref_r;
			int_r <= int_nxt;
		end
	end

	assign SDA_OUT = 1'b0;
	assign SDA_OE = sda_oe_link;
	assign EXPANDER_PORT_PINS_OUT = '0;
	assign EXPANDER_PORT_PINS_OE = port_low_r;
	assign INT_OUT = 1'b0;
	assign INT_OE = int_r;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n);

	a_prefix_low: assert property (addr_hit && !HIGH_RANGE |-> rx_byte[7:4] == 4'h4)
		else $error("low-range acknowledge with wrong prefix");
	a_prefix_high: assert property (addr_hit && HIGH_RANGE |-> rx_byte[7:4] == 4'h7)
		else $error("high-range acknowledge with wrong prefix");
	a_strap_bits: assert property (addr_hit |-> rx_byte[3:1] == samp_r.strap)
		else $error("acknowledged address does not match straps");
	a_foreign_silent: assert property (addr_miss |=> !drive_r && state_r == expander_pkg::ST_IDLE
		##1 !drive_r)
		else $error("foreign address was answered");
	a_port_write: assert property (ack_rise && state_r == expander_pkg::ST_WRITE
		|=> EXPANDER_PORT_PINS_OE == ~$past(wr_byte_r) && EXPANDER_PORT_PINS_OUT == 8'h00)
		else $error("written byte not reflected on open-drain port");
	a_int_cause: assert property ($rose(INT_OE) |-> $past(|pin_diff || |pin_edge)
		&& INT_OUT == 1'b0)
		else $error("alert asserted without a pin change");
	a_int_release: assert property (alert_clear && !(|pin_edge)
		|-> ##[1:ALERT_REL_CYC] !INT_OE)
		else $error("alert not released in time after acknowledge");
	a_reset_state: assert property ($rose(rst_n) |-> EXPANDER_PORT_PINS_OE == 8'h00
		&& !INT_OE)
		else $error("ports or alert wrong after reset");
	a_edge_alert: assert property (|pin_diff && !alert_clear |-> ##[1:2] INT_OE)
		else $error("input edge did not raise alert");
	a_rw_taken: assert property (addr_hit |=> rw_r == $past(rx_byte[0]))
		else $error("direction bit not taken");

	c_write: cover property (ack_rise && state_r == expander_pkg::ST_WRITE);
	c_read: cover property (rd_clear);
	c_alert_cleared: cover property (INT_OE ##1 alert_clear ##[1:4] !INT_OE);
	c_foreign: cover property (addr_miss);
endmodule // port_expander
`default_nettype wire

/* File: common/expander_pkg.sv */
// Shared constants and types of the I2C port expander
`default_nettype none
package expander_pkg;
	localparam int PORT_WIDTH = 8;
	localparam int ADDR_WIDTH = 7;
	localparam logic [3:0] PREFIX_LOW_RANGE = 4'h4;
	localparam logic [3:0] PREFIX_HIGH_RANGE = 4'h7;
	localparam logic [7:0] PORT_RESET = 8'hff;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic RW_READ = 1'b1;
	localparam int CLK_FREQ_KHZ = 40000;
	localparam int ALERT_RELEASE_DELAY_NS = 4000;
	// Longest time, so rounded down
	localparam int ALERT_RELEASE_CYC = ALERT_RELEASE_DELAY_NS * CLK_FREQ_KHZ / 1000000;

	typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ} link_state_type;

	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
	} bus_event_type;

	typedef struct packed {
		logic scl;
		logic sda;
		logic [2:0] strap;
		logic [7:0] pins;
	} pin_sample_type;
endpackage
`default_nettype wire

/* File: rtl/link_shifter.sv */
// Logic clocked by SCL: receive shifter and SDA pull-down timing
`default_nettype none
module link_shifter
(
	input wire logic scl,
	input wire logic rst_n,
	input wire logic sda_in,
	input wire logic drive_low,
	output logic [7:0] rx_byte,
	output logic sda_oe
);
	logic [7:0] rx_r;
	logic oe_r;

	// SDA is stable while SCL is high, so take it at the rising edge
	always_ff @(posedge scl or negedge rst_n)
	begin
		if (!rst_n)
			rx_r <= '0;
		else
			rx_r <= {rx_r[6:0], sda_in};
	end

	// drive_low settles within three CLK cycles after SCL rises, well before the falling edge, so it is safe to take here
	always_ff @(negedge scl or negedge rst_n)
	begin
		if (!rst_n)
			oe_r <= 1'b0;
		else
			oe_r <= drive_low;
	end

	assign rx_byte = rx_r;
	assign sda_oe = oe_r;
endmodule // link_shifter
`default_nettype wire

/* File: sim/i2c_master_model.sv */
// Behavioural I2C bus master that clocks SCL from the link clock
`default_nettype none
module i2c_master_model
(
	input wire logic lclk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 100ps;
	// SCL stands high between frames, as a real master leaves it
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Data moves only while SCL is low; SCL high lasts two link ticks
	task automatic bit_io(input logic d, output logic q);
	begin
		@(posedge lclk) scl <= 1'b0;
		@(posedge lclk) sda_low <= ~d;
		@(posedge lclk) scl <= 1'b1;
		@(posedge lclk) q = sda;
	end
	endtask
	task automatic start;
	begin
		@(posedge lclk) sda_low <= 1'b1;
	end
	endtask
	task automatic stop;
	begin
		@(posedge lclk) scl <= 1'b0;
		@(posedge lclk) sda_low <= 1'b1;
		@(posedge lclk) scl <= 1'b1;
		@(posedge lclk) sda_low <= 1'b0;
	end
	endtask
	// Sends MSB first, then releases SDA for the acknowledge
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic q;
	begin
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], q);
		bit_io(1'b1, q);
		ack = ~q;
	end
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic q;
	begin
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(nack, q);
	end
	endtask
endmodule // i2c_master_model
`default_nettype wire

/* File: sim/port_expander_bench.sv */
// Self-checking bench of the I2C port expander
`default_nettype none
module port_expander_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, lclk, rst_b, scl, m_low, ack;
	logic sda_oe, sda_out, int_oe, int_out, sda_oe_hi, sda_out_hi, int_oe_hi;
	logic [7:0] pin_low, port_oe, port_out, port_oe_hi, port_out_hi, rd;
	int err_total, tests_run;
	int cyc = 0;
	// Open-drain lines: an enabled driver shows its output level, else the pull-up wins
	wire sda = ~m_low & (~sda_oe | sda_out) & (~sda_oe_hi | sda_out_hi);
	wire int_line = ~int_oe | int_out;
	wire [7:0] pins = ~pin_low & (~port_oe | port_out);
	wire [7:0] pins_hi = ~port_oe_hi | port_out_hi;
	// Both variants share the bus, so each must ignore the other's address
	port_expander #(.HIGH_RANGE(1'b0)) dut (.CLK(clk), .RST_B(rst_b), .SCL(scl),
		.SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.ADDR_STRAP(3'h5),
		.EXPANDER_PORT_PINS_IN(pins), .EXPANDER_PORT_PINS_OUT(port_out),
		.EXPANDER_PORT_PINS_OE(port_oe), .INT_OUT(int_out), .INT_OE(int_oe));
	port_expander #(.HIGH_RANGE(1'b1)) dut_hi (.CLK(clk), .RST_B(rst_b), .SCL(scl),
		.SDA_IN(sda), .SDA_OUT(sda_out_hi), .SDA_OE(sda_oe_hi),
		.ADDR_STRAP(3'h2),
		.EXPANDER_PORT_PINS_IN(pins_hi), .EXPANDER_PORT_PINS_OUT(port_out_hi),
		.EXPANDER_PORT_PINS_OE(port_oe_hi), .INT_OUT(), .INT_OE(int_oe_hi));
	i2c_master_model m (.lclk(lclk), .sda(sda), .scl(scl), .sda_low(m_low));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		lclk = 1'b0;
		// Offset keeps link edges away from the system clock edges
		#7.3;
		forever #62.5 lclk = ~lclk;
	end
	// Six frames take some 2100 cycles; the ceiling leaves ample margin
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			complete_run();
		end
	end
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
	begin
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	end
	endtask
	task automatic t_reset;
	begin
		@(posedge clk) rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		check("port_oe", 8'h00, port_oe);
		check("port_oe_hi", 8'h00, port_oe_hi);
		check("int_line", 8'h01, {7'h00, int_line});
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		check("port_oe", 8'h00, port_oe);
		check("int_line", 8'h01, {7'h00, int_line});
		$display("test reset done");
	end
	endtask
	task automatic t_write;
	begin
		m.start();
		m.wbyte({4'h4, 3'h5, 1'b0}, ack);
		check("addr_ack", 8'h01, {7'h00, ack});
		m.wbyte(8'ha5, ack);
		check("data_ack", 8'h01, {7'h00, ack});
		m.stop();
		check("port_oe", 8'h5a, port_oe);
		check("port_pins", 8'ha5, pins);
		check("port_oe_hi", 8'h00, port_oe_hi);
		$display("test write done");
	end
	endtask
	// Foreign prefix and a strap mismatch must both stay unanswered
	task automatic t_foreign;
		logic [6:0] bad[2];
	begin
		bad[0] = {4'h7, 3'h5};
		bad[1] = {4'h4, 3'h4};
		for (int i = 0; i < 2; i++)
		begin
			m.start();
			m.wbyte({bad[i], 1'b0}, ack);
			check("foreign_ack", 8'h00, {7'h00, ack});
			m.stop();
		end
		check("port_oe", 8'h5a, port_oe);
		check("port_oe_hi", 8'h00, port_oe_hi);
		$display("test foreign done");
	end
	endtask
	// The high-range device answers its own prefix and leaves the low one alone
	task automatic t_high;
	begin
		m.start();
		m.wbyte({4'h7, 3'h2, 1'b0}, ack);
		check("hi_addr_ack", 8'h01, {7'h00, ack});
		m.wbyte(8'h3c, ack);
		check("hi_data_ack", 8'h01, {7'h00, ack});
		m.stop();
		check("port_oe_hi", 8'hc3, port_oe_hi);
		check("port_oe", 8'h5a, port_oe);
		check("int_oe_hi", 8'h00, {7'h00, int_oe_hi});
		$display("test high range done");
	end
	endtask
	task automatic t_alert;
	begin
		@(posedge clk) pin_low <= 8'h01;
		repeat (8) @(posedge clk);
		check("int_line", 8'h00, {7'h00, int_line});
		m.start();
		m.wbyte({4'h4, 3'h5, 1'b1}, ack);
		check("rd_ack", 8'h01, {7'h00, ack});
		repeat (150) @(posedge clk);
		check("int_line", 8'h01, {7'h00, int_line});
		m.rbyte(1'b1, rd);
		m.stop();
		check("rd_data", 8'ha4, rd);
		// A rising input edge alerts as well; the write acknowledge then clears it
		@(posedge clk) pin_low <= 8'h00;
		repeat (8) @(posedge clk);
		check("int_line", 8'h00, {7'h00, int_line});
		m.start();
		m.wbyte({4'h4, 3'h5, 1'b0}, ack);
		check("wr_ack", 8'h01, {7'h00, ack});
		m.wbyte(8'ha5, ack);
		m.stop();
		check("int_line", 8'h01, {7'h00, int_line});
		$display("test alert done");
	end
	endtask
	task automatic complete_run;
	begin
		$display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	initial
	begin
		rst_b = 1'b0;
		pin_low = 8'h00;
		err_total = 0;
		tests_run = 0;
		t_reset();
		t_write();
		t_foreign();
		t_high();
		t_alert();
		// A second reset at the end of the run must undo the written port value
		t_reset();
		complete_run();
	end
endmodule // port_expander_bench
`default_nettype wire
